/* src/edma_map.vh */
// Register offsets, field positions and constants of the external DMA channel
`ifndef EDMA_MAP_VH
`define EDMA_MAP_VH
`define EDMA_ADDR_W 24
`define EDMA_OFF_ICR 24'hFFFB90
`define EDMA_OFF_PINSEL 24'hFFFBC8
`define EDMA_OFF_SAR 24'hFFFC80
`define EDMA_OFF_DAR 24'hFFFC84
`define EDMA_OFF_TCR 24'hFFFC8C
`define EDMA_OFF_BSR 24'hFFFC90
`define EDMA_OFF_MDR 24'hFFFC94
`define EDMA_OFF_ACR 24'hFFFC98
`define EDMA_OFF_IRQ_STAT 24'hFFFCA0
`define EDMA_OFF_IRQ_CLR 24'hFFFCA4
`define EDMA_OFF_IRQ_EN 24'hFFFCA8
`define EDMA_MDR_EN 31
`define EDMA_MDR_REQS 27
`define EDMA_MDR_FLAG 16
`define EDMA_MDR_SZ_HI 15
`define EDMA_MDR_SZ_LO 14
`define EDMA_MDR_MD_HI 13
`define EDMA_MDR_MD_LO 12
`define EDMA_MDR_IE 8
`define EDMA_MDR_TRG_HI 7
`define EDMA_MDR_TRG_LO 6
`define EDMA_MDR_PRI_HI 2
`define EDMA_ACR_AMS 31
`define EDMA_ACR_SAT_HI 21
`define EDMA_ACR_SAT_LO 20
`define EDMA_ACR_DAT_HI 17
`define EDMA_ACR_DAT_LO 16
`define EDMA_SZ_BYTE 2'h0
`define EDMA_SZ_WORD 2'h1
`define EDMA_SZ_LONG 2'h2
`define EDMA_MODE_BLOCK 2'h1
`define EDMA_TRG_EXT 2'h3
`define EDMA_UPD_INC 2'h2
`define EDMA_UPD_DEC 2'h3
`define EDMA_PINSEL_P1 2'h0
`define EDMA_ICR_REQ_BIT 0
`define EDMA_IRQ_END 0
`define EDMA_IRQ_BLOCK 1
`endif

/* src/edma_channel.v */
// One external DMA channel: registers, request detection and dual-address block transfers
// What this block does
// - Source address register advances after each transfer
// - Destination address register advances after each transfer
// - Total count drops by access size per transfer
// - Enable bit 31 clear means no transfers
// - Bit 27 selects edge; first after enable level
// - Bits 15:14 choose access size, 00 byte
// - Bits 13:12 choose mode, 01 block
// - Bit 8 gates transfer-end interrupt request
// - Bits 7:6 choose trigger, 11 external
// - Bits 2:0 give priority over CPU
// - Block size upper half reloads remaining count
// - Address control bit 31 clear: dual addressing
// - Bits 21:20 set source update, 10 increment
// - Bits 17:16 set destination update, 10 increment
// - Pin-select field routes control pins, 00 P10-13
// - Request pin buffer on only with control bit
// - Mode bit 16 flags transfer-end request
`include "edma_map.vh"
module edma_channel #(
  parameter DATA_W = 32,
  parameter BUS_W = 32
)(
  input wire i_clock,
  input wire i_reset,
  input wire [23:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_write,
  input wire i_reg_read,
  output reg [31:0] o_reg_rdata,
  input wire [3:0] i_request_pins_n,
  output reg [BUS_W-1:0] o_bus_addr,
  output reg o_bus_read,
  output reg o_bus_write,
  output reg [1:0] o_bus_size,
  output reg [31:0] o_bus_wdata,
  input wire [31:0] i_bus_rdata,
  input wire i_bus_ready,
  output reg o_bus_request,
  output reg [2:0] o_bus_priority,
  input wire i_bus_grant,
  output reg o_irq,
  output reg o_busy
);
  localparam ST_IDLE = 2'h0;
  localparam ST_READ = 2'h1;
  localparam ST_WRITE = 2'h2;
  reg [7:0] icr_reg;
  reg [7:0] pinsel_reg;
  reg [31:0] sar_reg;
  reg [31:0] dar_reg;
  reg [31:0] tcr_reg;
  reg [31:0] bsr_reg;
  reg [31:0] mdr_reg;
  reg [31:0] acr_reg;
  reg [1:0] irq_stat_reg;
  reg [1:0] irq_en_reg;
  reg [1:0] state_reg;
  reg [31:0] data_reg;
  reg req_sync1_reg;
  reg req_sync2_reg;
  reg req_prev_reg;
  reg first_reg;
  reg pend_reg;
  reg [1:0] state_next;
  wire [1:0] size_code;
  wire [31:0] step;
  wire req_line_n;
  wire req_low;
  wire req_fall;
  wire wr_icr;
  wire wr_pinsel;
  wire wr_sar;
  wire wr_dar;
  wire wr_tcr;
  wire wr_bsr;
  wire wr_mdr;
  wire wr_acr;
  wire ext_mode;
  wire xfer_done;
  wire count_end;
  wire block_end;
  wire enabled;
  wire wr_irq_en;
  wire wr_irq_clr;
  wire start_xfer;
  wire [31:0] sar_next;
  wire [31:0] dar_next;
  wire [31:0] tcr_next;
  wire [31:0] bsr_next;
  function [31:0] edma_update;
    input [31:0] addr;
    input [1:0] mode;
    input [31:0] inc;
    begin
      case (mode)
        `EDMA_UPD_INC: edma_update = addr + inc;
        `EDMA_UPD_DEC: edma_update = addr - inc;
        default: edma_update = addr;
      endcase
    end
  endfunction
  function edma_hit;
    input [23:0] addr;
    input [23:0] off;
    begin
      edma_hit = (addr == off);
    end
  endfunction
  assign size_code = mdr_reg[`EDMA_MDR_SZ_HI:`EDMA_MDR_SZ_LO];
  assign step = (size_code == `EDMA_SZ_BYTE) ? 32'h00000001 :
                (size_code == `EDMA_SZ_WORD) ? 32'h00000002 : 32'h00000004;
  // Only the P10..P13 routing is wired; other codes leave the request idle
  assign req_line_n = (pinsel_reg[1:0] == `EDMA_PINSEL_P1) ?
    (req_sync2_reg | ~icr_reg[`EDMA_ICR_REQ_BIT]) : 1'b1;
  assign wr_icr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_ICR);
  assign wr_pinsel = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_PINSEL);
  assign wr_sar = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_SAR);
  assign wr_dar = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_DAR);
  assign wr_tcr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_TCR);
  assign wr_bsr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_BSR);
  assign wr_mdr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_MDR);
  assign wr_acr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_ACR);
  assign wr_irq_en = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_IRQ_EN);
  assign wr_irq_clr = i_reg_write && edma_hit(i_reg_addr, `EDMA_OFF_IRQ_CLR);
  assign enabled = mdr_reg[`EDMA_MDR_EN];
  assign ext_mode = mdr_reg[`EDMA_MDR_TRG_HI:`EDMA_MDR_TRG_LO] == `EDMA_TRG_EXT;
  // Buffer gated input, requester keeps it low or gives falling edges
  assign req_low = ~req_line_n;
  assign req_fall = req_prev_reg & ~req_line_n;
  assign xfer_done = (state_reg == ST_WRITE) && i_bus_ready;
  assign count_end = xfer_done && (tcr_reg <= step);
  assign block_end = xfer_done && (bsr_reg[15:0] <= step[15:0]);
  // A request is consumed only when the engine actually leaves idle
  assign start_xfer = (state_reg == ST_IDLE) && (state_next == ST_READ);
  assign sar_next = edma_update(sar_reg, acr_reg[`EDMA_ACR_SAT_HI:`EDMA_ACR_SAT_LO],
    step);
  assign dar_next = edma_update(dar_reg, acr_reg[`EDMA_ACR_DAT_HI:`EDMA_ACR_DAT_LO],
    step);
  assign tcr_next = count_end ? 32'h00000000 : tcr_reg - step;
  assign bsr_next = block_end ? {bsr_reg[31:16], bsr_reg[31:16]} :
    {bsr_reg[31:16], bsr_reg[15:0] - step[15:0]};
  // Request pin synchroniser ahead of the input buffer gate
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      req_sync1_reg <= 1'b1;
      req_sync2_reg <= 1'b1;
      req_prev_reg <= 1'b1;
    end
    else
    begin
      req_sync1_reg <= i_request_pins_n[0];
      req_sync2_reg <= req_sync1_reg;
      req_prev_reg <= req_line_n;
    end
  end
  // Request latch: level for the first transfer after enable, then edges when bit 27 is set
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      pend_reg <= 1'b0;
      first_reg <= 1'b1;
    end
    else if (!enabled || !ext_mode)
    begin
      pend_reg <= 1'b0;
      first_reg <= 1'b1;
    end
    else if (start_xfer)
    begin
      pend_reg <= 1'b0;
      first_reg <= 1'b0;
    end
    else if (!mdr_reg[`EDMA_MDR_REQS] || first_reg)
    begin
      pend_reg <= pend_reg | (req_low && state_reg == ST_IDLE);
    end
    else
    begin
      pend_reg <= pend_reg | req_fall;
    end
  end
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
      begin
        if (enabled && pend_reg && i_bus_grant && !acr_reg[`EDMA_ACR_AMS])
        begin
          state_next = ST_READ;
        end
      end
      ST_READ:
      begin
        if (i_bus_ready)
        begin
          state_next = ST_WRITE;
        end
      end
      ST_WRITE:
      begin
        if (!i_bus_ready)
        begin
          state_next = ST_WRITE;
        end
        else if (mdr_reg[`EDMA_MDR_MD_HI:`EDMA_MDR_MD_LO] == `EDMA_MODE_BLOCK
                 && !block_end && !count_end)
        begin
          state_next = ST_READ;
        end
        else
        begin
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end
  // State of the transfer engine and the unit held between read and write
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      state_reg <= ST_IDLE;
      data_reg <= 32'h00000000;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == ST_READ && i_bus_ready)
      begin
        data_reg <= i_bus_rdata;
      end
    end
  end
  // Configuration registers that only software writes
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      icr_reg <= 8'h00;
      pinsel_reg <= 8'h00;
      acr_reg <= 32'h00000000;
      irq_en_reg <= 2'h0;
    end
    else
    begin
      if (wr_icr)
      begin
        icr_reg <= i_reg_wdata[7:0];
      end
      if (wr_pinsel)
      begin
        pinsel_reg <= i_reg_wdata[7:0];
      end
      if (wr_acr)
      begin
        acr_reg <= i_reg_wdata;
      end
      if (wr_irq_en)
      begin
        irq_en_reg <= i_reg_wdata[1:0];
      end
    end
  end
  // Address and count registers; a completing unit wins over a software write
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      sar_reg <= 32'h00000000;
      dar_reg <= 32'h00000000;
      tcr_reg <= 32'h00000000;
      bsr_reg <= 32'h00000000;
    end
    else if (xfer_done)
    begin
      sar_reg <= sar_next;
      dar_reg <= dar_next;
      tcr_reg <= tcr_next;
      bsr_reg <= bsr_next;
    end
    else
    begin
      if (wr_sar)
      begin
        sar_reg <= i_reg_wdata;
      end
      if (wr_dar)
      begin
        dar_reg <= i_reg_wdata;
      end
      if (wr_tcr)
      begin
        tcr_reg <= i_reg_wdata;
      end
      if (wr_bsr)
      begin
        bsr_reg <= i_reg_wdata;
      end
    end
  end
  // Mode register and sticky status; a hardware set wins over a write or clear
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      mdr_reg <= 32'h00000000;
      irq_stat_reg <= 2'h0;
    end
    else
    begin
      if (count_end)
      begin
        mdr_reg <= ((wr_mdr ? i_reg_wdata : mdr_reg) | (32'h00000001 << `EDMA_MDR_FLAG)) &
          ~(32'h00000001 << `EDMA_MDR_EN);
      end
      else if (wr_mdr)
      begin
        mdr_reg <= i_reg_wdata;
      end
      irq_stat_reg[`EDMA_IRQ_END] <= count_end | (irq_stat_reg[`EDMA_IRQ_END] &
        ~(wr_irq_clr && i_reg_wdata[0]));
      irq_stat_reg[`EDMA_IRQ_BLOCK] <= block_end | (irq_stat_reg[`EDMA_IRQ_BLOCK] &
        ~(wr_irq_clr && i_reg_wdata[1]));
    end
  end
  // Bus outputs and readback
  always @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      o_reg_rdata <= 32'h00000000;
      o_bus_addr <= {BUS_W{1'b0}};
      o_bus_read <= 1'b0;
      o_bus_write <= 1'b0;
      o_bus_size <= 2'h0;
      o_bus_wdata <= 32'h00000000;
      o_bus_request <= 1'b0;
      o_bus_priority <= 3'h0;
      o_irq <= 1'b0;
      o_busy <= 1'b0;
    end
    else
    begin
      o_bus_read <= state_next == ST_READ;
      o_bus_write <= state_next == ST_WRITE;
      o_bus_addr <= (state_next == ST_WRITE) ? dar_reg[BUS_W-1:0] :
        (xfer_done ? sar_next[BUS_W-1:0] : sar_reg[BUS_W-1:0]);
      o_bus_wdata <= (state_reg == ST_READ) ? i_bus_rdata : data_reg;
      o_bus_size <= size_code;
      o_bus_request <= enabled && pend_reg;
      o_bus_priority <= mdr_reg[`EDMA_MDR_PRI_HI:0];
      o_irq <= (mdr_reg[`EDMA_MDR_IE] && mdr_reg[`EDMA_MDR_FLAG]) ||
        |(irq_stat_reg & irq_en_reg);
      o_busy <= state_next != ST_IDLE;
      o_reg_rdata <= 32'h00000000;
      if (i_reg_read)
      begin
        case (i_reg_addr)
          `EDMA_OFF_ICR: o_reg_rdata <= {24'h000000, icr_reg};
          `EDMA_OFF_PINSEL: o_reg_rdata <= {24'h000000, pinsel_reg};
          `EDMA_OFF_SAR: o_reg_rdata <= sar_reg;
          `EDMA_OFF_DAR: o_reg_rdata <= dar_reg;
          `EDMA_OFF_TCR: o_reg_rdata <= tcr_reg;
          `EDMA_OFF_BSR: o_reg_rdata <= bsr_reg;
          `EDMA_OFF_MDR: o_reg_rdata <= mdr_reg;
          `EDMA_OFF_ACR: o_reg_rdata <= acr_reg;
          `EDMA_OFF_IRQ_STAT: o_reg_rdata <= {30'h00000000, irq_stat_reg};
          `EDMA_OFF_IRQ_EN: o_reg_rdata <= {30'h00000000, irq_en_reg};
          default: o_reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

/* verification/edma_channel_chk.sv */
// Concurrent checks on the ports of the external DMA channel
module edma_chk #(
  parameter BUS_W = 32
)(
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic i_reg_read,
  input wire logic [31:0] o_reg_rdata,
  input wire logic [BUS_W-1:0] o_bus_addr,
  input wire logic o_bus_read,
  input wire logic o_bus_write,
  input wire logic [31:0] o_bus_wdata,
  input wire logic [31:0] i_bus_rdata,
  input wire logic i_bus_ready,
  input wire logic i_bus_grant,
  input wire logic o_busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);
  sequence s_rd_done;
    o_bus_read && i_bus_ready;
  endsequence
  sequence s_wr_done;
    o_bus_write && i_bus_ready;
  endsequence
  a_read_holds: assert property (o_bus_read && !i_bus_ready |=> o_bus_read && $stable(o_bus_addr))
    else $error("source read dropped early");
  a_write_holds: assert property (o_bus_write && !i_bus_ready |=> o_bus_write && $stable(o_bus_wdata))
    else $error("destination write dropped early");
  a_read_then_write: assert property (s_rd_done |=> o_bus_write && !o_bus_read)
    else $error("no write after read");
  a_wdata_from_read: assert property (s_rd_done |=> o_bus_wdata == $past(i_bus_rdata))
    else $error("write data differs from read data");
  a_write_ends: assert property (s_wr_done |=> !o_bus_write)
    else $error("write held after ready");
  a_start_granted: assert property ($rose(o_busy) |-> $past(i_bus_grant))
    else $error("transfer started without grant");
  a_busy_covers: assert property ((o_bus_read || o_bus_write) |-> o_busy)
    else $error("access while not busy");
  a_rdata_quiet: assert property (!$past(i_reg_read) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
endmodule
bind edma_channel edma_chk #(.BUS_W(BUS_W)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
  .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata), .o_bus_addr(o_bus_addr),
  .o_bus_read(o_bus_read), .o_bus_write(o_bus_write), .o_bus_wdata(o_bus_wdata),
  .i_bus_rdata(i_bus_rdata), .i_bus_ready(i_bus_ready), .i_bus_grant(i_bus_grant),
  .o_busy(o_busy));

/* verification/edma_ext_model.sv */
// External memory areas and transfer requester facing the channel
module edma_ext_model (
  input wire logic i_clock,
  input wire logic i_reset,
  input wire logic [31:0] i_addr,
  input wire logic i_read,
  input wire logic i_write,
  input wire logic [31:0] i_wdata,
  input wire logic i_request,
  input wire logic [1:0] i_wait,
  input wire logic i_req_low,
  output logic [31:0] o_rdata,
  output logic o_ready,
  output logic o_grant,
  output logic [3:0] o_req_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  logic [31:0] last;
  logic [1:0] cnt;
  initial for (int i = 0; i < 256; i++) mem[i] = 32'hC0DE0000 + i;
  // Ready after i_wait idle cycles; bus shows garbage when not read
  assign o_ready = (i_read || i_write) && cnt == i_wait;
  assign o_rdata = i_read ? mem[i_addr[7:0]] : ~last;
  assign o_grant = i_request;
  assign o_req_n = {3'h7, ~i_req_low};
  always @(posedge i_clock or posedge i_reset)
    if (i_reset)
    begin
      cnt <= 2'h0;
      last <= 32'h0;
    end
    else
    begin
      last <= o_rdata;
      cnt <= (o_ready || !(i_read || i_write)) ? 2'h0 : cnt + 2'h1;
      if (i_write && o_ready)
        mem[i_addr[7:0]] <= i_wdata;
    end
endmodule

/* verification/edma_channel_tb_top.sv */
// Self-checking bench for the external DMA channel
`include "edma_map.vh"
module edma_channel_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [23:0] a; logic [31:0] d; logic [31:0] e;} edma_row_t;
  logic i_clock = 0;
  logic i_reset = 1;
  logic [23:0] i_reg_addr = 24'h0;
  logic [31:0] i_reg_wdata = 32'h0;
  logic i_reg_write = 0;
  logic i_reg_read = 0;
  logic [31:0] o_reg_rdata, o_bus_addr, o_bus_wdata, i_bus_rdata, v;
  logic o_bus_read, o_bus_write, i_bus_ready, o_bus_request, i_bus_grant, o_irq, o_busy;
  logic [1:0] o_bus_size;
  logic [2:0] o_bus_priority;
  logic [3:0] i_request_pins_n;
  logic req_low = 0;
  logic [1:0] wait_cyc = 2'h0;
  int miscompares = 0;
  int tests_run = 0;
  edma_row_t rows [9] = '{'{`EDMA_OFF_SAR, 32'h12345678, 32'h12345678},
    '{`EDMA_OFF_DAR, 32'h89ABCDEF, 32'h89ABCDEF}, '{`EDMA_OFF_TCR, 32'h200, 32'h200},
    '{`EDMA_OFF_BSR, 32'h01000100, 32'h01000100}, '{`EDMA_OFF_ACR, 32'h220000, 32'h220000},
    '{`EDMA_OFF_ICR, 32'h1, 32'h1}, '{`EDMA_OFF_PINSEL, 32'h0, 32'h0},
    '{`EDMA_OFF_IRQ_CLR, 32'h3, 32'h0}, '{24'h000010, 32'hFFFFFFFF, 32'h0}};
  always #2.5 i_clock = ~i_clock;
  edma_channel u_edma_channel (.i_clock(i_clock), .i_reset(i_reset), .i_reg_addr(i_reg_addr),
    .i_reg_wdata(i_reg_wdata), .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
    .o_reg_rdata(o_reg_rdata), .i_request_pins_n(i_request_pins_n), .o_bus_addr(o_bus_addr),
    .o_bus_read(o_bus_read), .o_bus_write(o_bus_write), .o_bus_size(o_bus_size),
    .o_bus_wdata(o_bus_wdata), .i_bus_rdata(i_bus_rdata), .i_bus_ready(i_bus_ready),
    .o_bus_request(o_bus_request), .o_bus_priority(o_bus_priority), .i_bus_grant(i_bus_grant),
    .o_irq(o_irq), .o_busy(o_busy));
  edma_ext_model u_edma_ext_model (.i_clock(i_clock), .i_reset(i_reset), .i_addr(o_bus_addr),
    .i_read(o_bus_read), .i_write(o_bus_write), .i_wdata(o_bus_wdata),
    .i_request(o_bus_request), .i_wait(wait_cyc), .i_req_low(req_low), .o_rdata(i_bus_rdata),
    .o_ready(i_bus_ready), .o_grant(i_bus_grant), .o_req_n(i_request_pins_n));
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [23:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_write <= 1;
    @(posedge i_clock);
    i_reg_write <= 0;
  endtask
  task automatic rd(input logic [23:0] a, input logic [31:0] e, input string n);
    @(posedge i_clock);
    i_reg_addr <= a;
    i_reg_read <= 1;
    @(posedge i_clock);
    i_reg_read <= 0;
    #1 chk(n, e, o_reg_rdata);
  endtask
  // Bounded wait for one busy period to start and finish
  task automatic wait_busy(input logic exp);
    int k;
    for (k = 0; k < 100 && o_busy !== 1; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    chk("busy", {31'h0, exp}, {31'h0, o_busy});
    for (k = 0; k < 200 && o_busy !== 0; k++)
    begin
      @(posedge i_clock);
      #1;
    end
    if (o_busy !== 0)
    begin
      miscompares++;
      end_sim;
    end
  endtask
  initial
  begin
    repeat (5) @(posedge i_clock);
    i_reset <= 0;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e, "reg");
    end
    wr(`EDMA_OFF_SAR, 32'h10);
    wr(`EDMA_OFF_DAR, 32'h40);
    wr(`EDMA_OFF_TCR, 32'h4);
    wr(`EDMA_OFF_BSR, 32'h00020002);
    wr(`EDMA_OFF_IRQ_EN, 32'h1);
    wr(`EDMA_OFF_MDR, 32'h880011C7);
    @(posedge i_clock);
    req_low <= 1;
    #1 chk("prio", 32'h7, {29'h0, o_bus_priority});
    wait_busy(1);
    chk("size", 32'h0, {30'h0, o_bus_size});
    rd(`EDMA_OFF_SAR, 32'h12, "sar");
    rd(`EDMA_OFF_DAR, 32'h42, "dar");
    rd(`EDMA_OFF_TCR, 32'h2, "tcr");
    rd(`EDMA_OFF_BSR, 32'h00020002, "bsr");
    chk("mem", 32'hC0DE0011, u_edma_ext_model.mem[8'h41]);
    repeat (20) @(posedge i_clock);
    rd(`EDMA_OFF_SAR, 32'h12, "sar_level");
    @(posedge i_clock);
    wait_cyc <= 2'h2;
    req_low <= 0;
    repeat (4) @(posedge i_clock);
    req_low <= 1;
    wait_busy(1);
    rd(`EDMA_OFF_SAR, 32'h14, "sar_end");
    rd(`EDMA_OFF_TCR, 32'h0, "tcr_end");
    rd(`EDMA_OFF_MDR, 32'h080111C7, "mdr_end");
    rd(`EDMA_OFF_IRQ_STAT, 32'h3, "stat");
    chk("irq", 32'h1, {31'h0, o_irq});
    @(posedge i_clock);
    req_low <= 0;
    repeat (4) @(posedge i_clock);
    req_low <= 1;
    wait_busy(0);
    chk("request", 32'h0, {31'h0, o_bus_request});
    rd(`EDMA_OFF_SAR, 32'h14, "sar_off");
    wr(`EDMA_OFF_IRQ_CLR, 32'h3);
    rd(`EDMA_OFF_IRQ_STAT, 32'h0, "stat_clr");
    wr(`EDMA_OFF_MDR, 32'h080110C7);
    repeat (3) @(posedge i_clock);
    #1 chk("irq_mask", 32'h0, {31'h0, o_irq});
    wr(`EDMA_OFF_MDR, 32'h080011C7);
    rd(`EDMA_OFF_MDR, 32'h080011C7, "mdr_clr");
    chk("irq_clr", 32'h0, {31'h0, o_irq});
    // Reset while the channel is disabled and idle, then word units, level requests, decrementing source
    @(posedge i_clock);
    i_reset <= 1;
    repeat (2) @(posedge i_clock);
    i_reset <= 0;
    rd(`EDMA_OFF_SAR, 32'h0, "sar_rst");
    rd(`EDMA_OFF_MDR, 32'h0, "mdr_rst");
    chk("prio_rst", 32'h0, {29'h0, o_bus_priority});
    wr(`EDMA_OFF_ICR, 32'h1);
    wr(`EDMA_OFF_SAR, 32'h20);
    wr(`EDMA_OFF_DAR, 32'h60);
    wr(`EDMA_OFF_TCR, 32'h4);
    wr(`EDMA_OFF_ACR, 32'h320000);
    wr(`EDMA_OFF_MDR, 32'h800040C0);
    wait_busy(1);
    wait_busy(1);
    rd(`EDMA_OFF_SAR, 32'h1C, "sar_dec");
    rd(`EDMA_OFF_DAR, 32'h64, "dar_word");
    rd(`EDMA_OFF_TCR, 32'h0, "tcr_word");
    rd(`EDMA_OFF_MDR, 32'h000140C0, "mdr_word");
    chk("size_word", 32'h1, {30'h0, o_bus_size});
    chk("mem_word", 32'hC0DE001E, u_edma_ext_model.mem[8'h62]);
    end_sim;
  end
endmodule
